/* tb.sv */
// self-checking testbench for the test program step store
`timescale 1ns/1ps
module tb import tpss_pkg::*;;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, prot = 1'b0, scr = 1'b0, start = 1'b0, stop = 1'b0, go = 1'b0, tst = 1'b0;
    logic [COND_W-1:0] cond = '0;
    logic val, flg, rdy, rv, rrep, cl, ge, rl, ra, sp;
    logic [3:0] op, fld, nl;
    logic [6:0] pg, st, mm, iv, rmem, rival, rcnt, rprog, rstep, rmm;
    logic [95:0] nm, rname;
    logic [COND_W-1:0] cdata;
    logic [7:0] esr;
    logic [9:0] sum;
    int n_fail = 0, checked = 0;
    initial forever #10 i_mclk = ~i_mclk;
    tpss_host h (.i_mclk(i_mclk), .i_ready(rdy), .o_valid(val), .o_op(op), .o_fields(fld), .o_prog(pg),
        .o_step(st), .o_mem(mm), .o_ival(iv), .o_flag(flg), .o_name(nm), .o_name_len(nl));
    tpss_top #(.TENTH_CYCLES(4)) dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_valid(val), .i_cmd_op(op),
        .i_cmd_fields(fld), .i_cmd_prog(pg), .i_cmd_step(st), .i_cmd_mem(mm), .i_cmd_ival(iv), .i_cmd_flag(flg),
        .i_cmd_name(nm), .i_cmd_name_len(nl), .i_present_cond(cond), .i_test_running(tst), .i_protect(prot),
        .i_auto_test_screen(scr), .i_run_start(start), .i_run_stop(stop), .i_operator_go(go), .o_cmd_ready(rdy),
        .o_rsp_valid(rv), .o_rsp_mem(rmem), .o_rsp_ival(rival), .o_rsp_name(rname), .o_rsp_repeat(rrep),
        .o_rsp_count(rcnt), .o_cond_load(cl), .o_cond_data(cdata), .o_esr_set(esr), .o_goto_edit_screen(ge),
        .o_run_loaded(rl), .o_run_prog(rprog), .o_run_active(ra), .o_run_step(rstep), .o_run_mem(rmm),
        .o_run_step_pulse(sp));
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // append on the auto screen, then refused writes leave the count alone
    task automatic t_write();
        scr <= 1'b1;
        h.cmd(OP_WRITE, 4'hf, 7'h01, 7'h00, 7'h05, 7'h7f);
        chk(ge === 1'b1 && esr === 8'h00, "no edit screen");
        scr <= 1'b0;
        h.cmd(OP_WRITE_Q, 4'h3, 7'h01, 7'h00);
        chk(rv === 1'b1 && rmem === 7'h05 && rival === 7'h7f, "step read");
        h.cmd(OP_WRITE, 4'hf, 7'h01, 7'h02, 7'h06, 7'h63);
        chk(esr[5] === 1'b1, "gap accepted");
        h.cmd(OP_WRITE, 4'h7, 7'h01, 7'h01, 7'h06);
        chk(esr[5] === 1'b1, "partial write");
        h.cmd(OP_COUNT_Q, 4'h1, 7'h01);
        chk(rcnt === 7'h01, "count after refusals");
    endtask
    // insert ahead, overwrite, remove the inserted step
    task automatic t_insert();
        h.cmd(OP_INSERT, 4'h7, 7'h01, 7'h00, 7'h09);
        h.cmd(OP_WRITE_Q, 4'h3, 7'h01, 7'h00);
        chk(rmem === 7'h09 && rival === 7'h0a, "inserted step");
        h.cmd(OP_WRITE, 4'hf, 7'h01, 7'h01, 7'h07, 7'h63);
        h.cmd(OP_REMOVE, 4'h3, 7'h01, 7'h00);
        h.cmd(OP_WRITE_Q, 4'h3, 7'h01, 7'h00);
        chk(rmem === 7'h07 && rival === 7'h63, "overwrite or shift");
        h.cmd(OP_COUNT_Q, 4'h1, 7'h01);
        chk(rcnt === 7'h01, "count after remove");
    endtask
    // names, repeat switch, condition memories, locked command
    task automatic t_misc();
        h.cmd(OP_NAME, 4'h1, 7'h02, .nm(96'h4241), .nl(4'h2));
        h.cmd(OP_NAME, 4'h1, 7'h02, .nm(96'h2c41), .nl(4'h2));
        chk(esr[5] === 1'b1, "comma accepted");
        h.cmd(OP_NAME_Q, 4'h1, 7'h02);
        chk(rname === 96'h4241, "name read");
        for (int f = 0; f < 2; f++) begin
            h.cmd(OP_REPEAT, 4'h1, 7'h03, .f(f[0]));
            h.cmd(OP_REPEAT_Q, 4'h1, 7'h03);
            chk(rrep === f[0], "repeat read");
        end
        cond <= 64'h0123456789abcdef;
        h.cmd(OP_SAVE_COND, 4'h1, 7'h03);
        cond <= '0;
        h.cmd(OP_LOAD_COND, 4'h1, 7'h03);
        chk(cl === 1'b1 && cdata === 64'h0123456789abcdef, "recall");
        h.cmd(OP_LOAD_COND, 4'h1, 7'h64);
        chk(esr[5] === 1'b1 && cl === 1'b0, "range");
        prot <= 1'b1;
        h.cmd(OP_CLEAR, 4'h1, 7'h01);
        chk(esr === 8'h10, "locked clear");
        {prot, tst} <= 2'b01;
        h.cmd(OP_CLEAR, 4'h1, 7'h01);
        chk(esr === 8'h10, "clear while testing");
        h.cmd(OP_COUNT_Q, 4'h1, 7'h01);
        chk(rv === 1'b1 && esr === 8'h00, "query while testing");
        tst <= 1'b0;
    endtask
    // select and start program 1, whose one step recalls memory 7
    task automatic t_run();
        h.cmd(OP_RUN_SEL, 4'h1, 7'h01);
        chk(rl === 1'b1 && rprog === 7'h01, "run select");
        start <= 1'b1;
        @(posedge i_mclk);
        start <= 1'b0;
        #1;
        chk(sp === 1'b1, "no step pulse");
        repeat (3) @(posedge i_mclk);
        #1;
        chk(ra === 1'b1 && rmm === 7'h07 && rstep === 7'h00, "run step");
        go <= 1'b1;
        repeat (400) @(posedge i_mclk);
        #1;
        chk(ra === 1'b0 && rstep === 7'h00, "ran past last step");
        stop <= 1'b1;
        @(posedge i_mclk);
        stop <= 1'b0;
    endtask
    // fill the shared pool with 5 x 100 steps; the sixth program is refused
    task automatic t_pool();
        h.cmd(OP_CLEAR, 4'h1, 7'h01);
        for (int p = 0; p < 5; p++) for (int s = 0; s < 100; s++) h.cmd(OP_WRITE, 4'hf, p[6:0], s[6:0], 7'h01, 7'h00);
        h.cmd(OP_WRITE, 4'hf, 7'h05, 7'h00, 7'h01, 7'h00);
        chk(esr[5] === 1'b1, "pool overflow");
        sum = '0;
        for (int p = 0; p < 6; p++) begin
            h.cmd(OP_COUNT_Q, 4'h1, p[6:0]);
            sum += {3'b000, rcnt};
        end
        chk(sum === 10'h1f4, "pool total");
        h.cmd(OP_CLEAR, 4'h1, 7'h00);
        h.cmd(OP_WRITE, 4'hf, 7'h05, 7'h00, 7'h01, 7'h00);
        chk(esr === 8'h00, "freed pool refused");
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        #1;
        chk(rdy === 1'b1 && rcnt === 7'h00 && esr === 8'h00, "reset state");
        t_write();
        t_insert();
        t_misc();
        t_run();
        t_pool();
        close_out();
    end
endmodule

/* tpss_checker.sv */
// port-level assertions for the test program step store
`timescale 1ns/1ps
module tpss_checker import tpss_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_op,
    input wire logic [3:0] i_cmd_fields,
    input wire logic [6:0] i_cmd_prog,
    input wire logic [3:0] i_cmd_name_len,
    input wire logic i_test_running,
    input wire logic i_protect,
    input wire logic o_cmd_ready,
    input wire logic o_rsp_valid,
    input wire logic o_cond_load,
    input wire logic [7:0] o_esr_set,
    input wire logic o_run_loaded,
    input wire logic [6:0] o_run_prog,
    input wire logic o_run_active
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // taken command, and one that neither range nor lock refuses
    wire take = i_cmd_valid && o_cmd_ready;
    wire in_rng = i_cmd_fields[0] && (i_cmd_prog <= NUM_MAX);
    wire ok_cmd = take && in_rng && !i_test_running && !i_protect;
    a_count_answer: assert property (take && i_cmd_op == OP_COUNT_Q && in_rng |=> o_rsp_valid && o_esr_set == 8'h00)
        else $error("count query not answered");
    a_range_error: assert property (take && i_cmd_fields[0] && i_cmd_prog > NUM_MAX |=> o_esr_set[5] && !o_rsp_valid)
        else $error("out of range number accepted");
    a_exec_error: assert property (take && i_cmd_op == OP_CLEAR && in_rng && (i_test_running || i_protect)
        |=> o_esr_set == 8'h10)
        else $error("locked clear not flagged");
    a_load_pulse: assert property (ok_cmd && i_cmd_op == OP_LOAD_COND |=> o_cond_load)
        else $error("recall gave no load pulse");
    a_missing_field: assert property (take && i_cmd_op == OP_WRITE && i_cmd_fields != 4'hf |=> o_esr_set[5])
        else $error("partial write accepted");
    a_name_length: assert property (take && i_cmd_op == OP_NAME && i_cmd_name_len > NAME_LEN_MAX |=> o_esr_set[5])
        else $error("long name accepted");
    a_run_select: assert property (ok_cmd && i_cmd_op == OP_RUN_SEL
        |=> o_run_loaded && !o_run_active && o_run_prog == $past(i_cmd_prog))
        else $error("run select not loaded");
    a_quiet_idle: assert property (!take |=> o_esr_set == 8'h00 && !o_rsp_valid && !o_cond_load)
        else $error("response without command");
    a_busy_bounded: assert property ($fell(o_cmd_ready) |-> ##[1:120] o_cmd_ready)
        else $error("shift never finished");
    c_insert: cover property (take && i_cmd_op == OP_INSERT);
    c_exec: cover property (o_esr_set[4]);
    c_run: cover property (o_run_active);
endmodule
bind tpss_top tpss_checker u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_fields(i_cmd_fields), .i_cmd_prog(i_cmd_prog), .i_cmd_name_len(i_cmd_name_len),
    .i_test_running(i_test_running), .i_protect(i_protect), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
    .o_cond_load(o_cond_load), .o_esr_set(o_esr_set), .o_run_loaded(o_run_loaded), .o_run_prog(o_run_prog),
    .o_run_active(o_run_active));

/* tpss_host.sv */
// remote host model: one command at a time on the command port
`timescale 1ns/1ps
module tpss_host #(
    parameter int HOLD_CYC = 4
) (
    input wire logic i_mclk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [3:0] o_op,
    output logic [3:0] o_fields,
    output logic [6:0] o_prog,
    output logic [6:0] o_step,
    output logic [6:0] o_mem,
    output logic [6:0] o_ival,
    output logic o_flag,
    output logic [95:0] o_name,
    output logic [3:0] o_name_len
);
    logic last_wr = 1'b0;
    initial begin
        {o_valid, o_op, o_fields, o_prog, o_step, o_mem, o_ival, o_flag, o_name, o_name_len} = '0;
    end
    // request held until the edge that takes it; program, step and memory scrambled after release
    task automatic cmd(input logic [3:0] op, input logic [3:0] fl, input logic [6:0] p, input logic [6:0] s = 7'h00,
        input logic [6:0] m = 7'h00, input logic [6:0] iv = 7'h00, input logic f = 1'b0,
        input logic [95:0] nm = 96'h0, input logic [3:0] nl = 4'h0);
        int n;
        n = 0;
        // acceptance time after write and insert, shortened for simulation
        if (last_wr) repeat (HOLD_CYC) @(posedge i_mclk);
        @(posedge i_mclk);
        {o_valid, o_op, o_fields, o_prog, o_step, o_mem, o_ival} <= {1'b1, op, fl, p, s, m, iv};
        {o_flag, o_name, o_name_len} <= {f, nm, nl};
        do begin
            @(negedge i_mclk);
            n++;
        end while (i_ready !== 1'b1 && n < 200);
        if (n >= 200) begin
            tb.n_fail++;
            tb.close_out();
        end
        @(posedge i_mclk);
        {o_valid, o_prog, o_step, o_mem} <= {1'b0, ~p, ~s, ~m};
        last_wr = op == 4'h3 || op == 4'h5;
        #1;
    endtask
endmodule

/* tpss_pkg.sv */
// shared constants and types for the test program step store
package tpss_pkg;
    // command codes presented by the message parser
    localparam logic [3:0] OP_LOAD_COND = 4'h0;
    localparam logic [3:0] OP_SAVE_COND = 4'h1;
    localparam logic [3:0] OP_REMOVE = 4'h2;
    localparam logic [3:0] OP_WRITE = 4'h3;
    localparam logic [3:0] OP_WRITE_Q = 4'h4;
    localparam logic [3:0] OP_INSERT = 4'h5;
    localparam logic [3:0] OP_NAME = 4'h6;
    localparam logic [3:0] OP_NAME_Q = 4'h7;
    localparam logic [3:0] OP_CLEAR = 4'h8;
    localparam logic [3:0] OP_REPEAT = 4'h9;
    localparam logic [3:0] OP_REPEAT_Q = 4'ha;
    localparam logic [3:0] OP_RUN_SEL = 4'hb;
    localparam logic [3:0] OP_COUNT_Q = 4'hc;
    // presence mask bit positions of i_cmd_fields
    localparam int FLD_PROG = 0;
    localparam int FLD_STEP = 1;
    localparam int FLD_MEM = 2;
    localparam int FLD_IVAL = 3;
    // ranges and sizes
    localparam logic [6:0] NUM_MAX = 7'h63;
    localparam int NUM_ENTRIES = 100;
    localparam logic [6:0] IVAL_MAX = 7'h63;
    localparam logic [6:0] IVAL_HOLD = 7'h7f;
    localparam logic [6:0] IVAL_INSERT = 7'h0a;
    localparam logic [8:0] POOL_MAX = 9'h1f4;
    localparam int NAME_CHARS = 12;
    localparam logic [3:0] NAME_LEN_MAX = 4'hc;
    localparam logic [7:0] CHAR_LOW = 8'h20;
    localparam logic [7:0] CHAR_HIGH = 8'h7e;
    localparam logic [7:0] CHAR_DQUOTE = 8'h22;
    localparam logic [7:0] CHAR_APOS = 8'h27;
    localparam logic [7:0] CHAR_COMMA = 8'h2c;
    localparam logic [7:0] CHAR_AT = 8'h40;
    localparam logic [95:0] NAME_RESET = 96'h0;
    // standard event status bit positions
    localparam int ESR_SYNTAX_BIT = 5;
    localparam int ESR_EXEC_BIT = 4;
    localparam int COND_W = 64;
    // interval resolution and clock
    localparam int IVAL_RES_NS = 100_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int TENTH_CYC = IVAL_RES_NS / CLK_PERIOD_NS;
    localparam logic [22:0] TICK_RESET = 23'h0;
    localparam logic [6:0] STEP_RESET = 7'h0;
    localparam logic [8:0] POOL_RESET = 9'h0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_PLACE = 3'b100
    } tpss_state_type;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b01,
        SQ_WAIT = 2'b10
    } tpss_seq_type;
endpackage

/* tpss_seq.sv */
// automatic test sequencer: walks the steps of the active program
`timescale 1ns/1ps
module tpss_seq import tpss_pkg::*; #(
    parameter int TENTH_CYCLES = TENTH_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [6:0] i_count,
    input wire logic i_repeat,
    input wire logic [6:0] i_ival,
    input wire logic i_operator_go,
    output logic [6:0] o_step,
    output logic o_active,
    output logic o_step_pulse
);
    tpss_seq_type state_reg, state_next;
    logic [22:0] tick_reg;
    logic [6:0] tenth_reg;
    logic [6:0] step_reg;
    logic pulse_reg;
    wire tick_wrap = tick_reg == 23'(TENTH_CYCLES - 1);
    // hold waits for the operator, otherwise the tenths count reaches the interval
    wire step_done = (i_ival == IVAL_HOLD) ? i_operator_go : (tenth_reg == i_ival);
    wire last_step = (step_reg + 7'h1) >= i_count;
    wire advance = (state_reg == SQ_WAIT) && step_done;

    // next state: end after last step unless repeat loops back to first
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SQ_IDLE: begin
                if (i_start && i_count != STEP_RESET) begin
                    state_next = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (i_stop || (advance && last_step && !i_repeat)) begin
                    state_next = SQ_IDLE;
                end
            end
        endcase
    end

    // counters restart on every step so each interval is measured from its start
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= SQ_IDLE;
            tick_reg <= TICK_RESET;
            tenth_reg <= STEP_RESET;
            step_reg <= STEP_RESET;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pulse_reg <= (state_reg == SQ_IDLE && state_next == SQ_WAIT) || (advance && state_next == SQ_WAIT);
            if (state_reg == SQ_IDLE || advance) begin
                tick_reg <= TICK_RESET;
                tenth_reg <= STEP_RESET;
                step_reg <= (state_reg == SQ_IDLE || last_step) ? STEP_RESET : step_reg + 7'h1;
            end else begin
                tick_reg <= tick_wrap ? TICK_RESET : tick_reg + 23'h1;
                tenth_reg <= tick_wrap ? tenth_reg + 7'h1 : tenth_reg;
            end
        end
    end

    assign o_step = step_reg;
    assign o_active = state_reg == SQ_WAIT;
    assign o_step_pulse = pulse_reg;
endmodule

/* tpss_top.sv */
// test program step store: condition memories, program steps and queries
`timescale 1ns/1ps
module tpss_top import tpss_pkg::*; #(
    parameter int TENTH_CYCLES = TENTH_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_op,
    input wire logic [3:0] i_cmd_fields,
    input wire logic [6:0] i_cmd_prog,
    input wire logic [6:0] i_cmd_step,
    input wire logic [6:0] i_cmd_mem,
    input wire logic [6:0] i_cmd_ival,
    input wire logic i_cmd_flag,
    input wire logic [95:0] i_cmd_name,
    input wire logic [3:0] i_cmd_name_len,
    input wire logic [COND_W-1:0] i_present_cond,
    input wire logic i_test_running,
    input wire logic i_protect,
    input wire logic i_auto_test_screen,
    input wire logic i_run_start,
    input wire logic i_run_stop,
    input wire logic i_operator_go,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic [6:0] o_rsp_mem,
    output logic [6:0] o_rsp_ival,
    output logic [95:0] o_rsp_name,
    output logic o_rsp_repeat,
    output logic [6:0] o_rsp_count,
    output logic o_cond_load,
    output logic [COND_W-1:0] o_cond_data,
    output logic [7:0] o_esr_set,
    output logic o_goto_edit_screen,
    output logic o_run_loaded,
    output logic [6:0] o_run_prog,
    output logic o_run_active,
    output logic [6:0] o_run_step,
    output logic [6:0] o_run_mem,
    output logic o_run_step_pulse
);
    // step entries kept per program at a fixed slot; the pool limit is a count
    logic [13:0] step_mem [0:NUM_ENTRIES*NUM_ENTRIES-1];
    logic [COND_W-1:0] cond_mem [0:NUM_ENTRIES-1];
    logic [6:0] cnt_arr [0:NUM_ENTRIES-1];
    logic [95:0] name_arr [0:NUM_ENTRIES-1];
    logic [NUM_ENTRIES-1:0] rep_reg;
    logic [8:0] pool_reg;
    tpss_state_type state_reg, state_next;
    logic [6:0] sh_idx_reg, sh_idx_next;
    logic [6:0] op_prog_reg, op_step_reg, op_mem_reg;
    logic op_ins_reg;
    logic [6:0] run_prog_reg;
    logic rsp_valid_reg, cond_load_reg, edit_reg, run_loaded_reg;
    logic [6:0] rsp_mem_reg, rsp_ival_reg, rsp_count_reg;
    logic [95:0] rsp_name_reg;
    logic rsp_rep_reg;
    logic [COND_W-1:0] cond_out_reg;
    logic [7:0] esr_reg;
    logic go_meta_reg, go_sync_reg;
    logic syn_err;
    logic [13:0] wr_addr;
    logic [13:0] wr_data;
    logic wr_en;

    // flat slot of a step within the step store
    function automatic logic [13:0] slot_of(input logic [6:0] prog, input logic [6:0] step);
        slot_of = 14'(prog) * 14'h64 + 14'(step);
    endfunction

    // a name is legal when short enough and every used character allowed
    function automatic logic name_ok(input logic [95:0] name, input logic [3:0] len);
        logic [7:0] ch;
        name_ok = len <= NAME_LEN_MAX;
        for (int k = 0; k < NAME_CHARS; k++) begin
            ch = name[8*k +: 8];
            if (4'(k) < len) begin
                if (ch < CHAR_LOW || ch > CHAR_HIGH || ch == CHAR_DQUOTE || ch == CHAR_APOS
                    || ch == CHAR_COMMA || ch == CHAR_AT) begin
                    name_ok = 1'b0;
                end
            end
        end
    endfunction

    // which fields each command needs
    function automatic logic [3:0] need_of(input logic [3:0] op);
        case (op)
            OP_WRITE: need_of = 4'hf;
            OP_REMOVE, OP_WRITE_Q: need_of = 4'h3;
            OP_INSERT: need_of = 4'h7;
            default: need_of = 4'h1;
        endcase
    endfunction

    // operand decode and checks
    wire cmd_go = i_cmd_valid && state_reg == ST_IDLE;
    wire p_bad = i_cmd_prog > NUM_MAX;
    wire s_bad = i_cmd_step > NUM_MAX;
    wire m_bad = i_cmd_mem > NUM_MAX;
    wire i_bad = (i_cmd_ival > IVAL_MAX) && (i_cmd_ival != IVAL_HOLD);
    wire [6:0] prog_ix = p_bad ? STEP_RESET : i_cmd_prog;
    wire [6:0] cur_cnt = cnt_arr[prog_ix];
    wire pool_full = pool_reg >= POOL_MAX;
    wire missing = (need_of(i_cmd_op) & ~i_cmd_fields) != 4'h0;
    wire gap = i_cmd_step > cur_cnt;
    wire append = i_cmd_step == cur_cnt;
    wire is_query = i_cmd_op == OP_WRITE_Q || i_cmd_op == OP_NAME_Q || i_cmd_op == OP_REPEAT_Q
        || i_cmd_op == OP_COUNT_Q;
    wire exe_err = (i_test_running || i_protect) && !is_query;
    wire [13:0] cmd_slot = slot_of(prog_ix, i_cmd_step);
    wire [13:0] q_entry = step_mem[cmd_slot];
    wire accept = cmd_go && !syn_err && !exe_err;
    wire do_op = accept;
    wire [6:0] run_cnt = cnt_arr[run_prog_reg];
    wire [6:0] run_step;
    wire [13:0] run_entry = step_mem[slot_of(run_prog_reg, run_step)];

    // per-command data and range errors; pool and gap refusals leave contents alone
    always_comb begin
        syn_err = p_bad || missing;
        unique case (i_cmd_op)
            OP_LOAD_COND, OP_SAVE_COND: syn_err = p_bad;
            OP_REMOVE: syn_err = syn_err || s_bad || i_cmd_step >= cur_cnt;
            OP_WRITE: syn_err = syn_err || s_bad || m_bad || i_bad || gap || (append && pool_full);
            OP_WRITE_Q: syn_err = syn_err || s_bad || i_cmd_step >= cur_cnt;
            OP_INSERT: syn_err = syn_err || s_bad || m_bad || gap || pool_full || cur_cnt > NUM_MAX;
            OP_NAME: syn_err = syn_err || !name_ok(i_cmd_name, i_cmd_name_len);
            OP_NAME_Q, OP_CLEAR, OP_REPEAT_Q, OP_RUN_SEL, OP_COUNT_Q: syn_err = syn_err;
            OP_REPEAT: syn_err = syn_err;
            default: syn_err = 1'b1;
        endcase
    end

    // shifting walks one entry per cycle; insert moves down, remove moves up
    always_comb begin
        state_next = state_reg;
        sh_idx_next = sh_idx_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (do_op && i_cmd_op == OP_INSERT) begin
                    state_next = append ? ST_PLACE : ST_SHIFT;
                    sh_idx_next = cur_cnt;
                end else if (do_op && i_cmd_op == OP_REMOVE) begin
                    state_next = (i_cmd_step + 7'h1 == cur_cnt) ? ST_PLACE : ST_SHIFT;
                    sh_idx_next = i_cmd_step;
                end
            end
            ST_SHIFT: begin
                if (op_ins_reg) begin
                    sh_idx_next = sh_idx_reg - 7'h1;
                    if (sh_idx_reg == op_step_reg + 7'h1) begin
                        state_next = ST_PLACE;
                    end
                end else begin
                    sh_idx_next = sh_idx_reg + 7'h1;
                    if (sh_idx_reg + 7'h2 == cnt_arr[op_prog_reg]) begin
                        state_next = ST_PLACE;
                    end
                end
            end
            ST_PLACE: state_next = ST_IDLE;
        endcase
    end

    // single write port into the step store
    always_comb begin
        wr_en = 1'b0;
        wr_addr = cmd_slot;
        wr_data = {i_cmd_mem, i_cmd_ival};
        if (state_reg == ST_IDLE && do_op && i_cmd_op == OP_WRITE) begin
            wr_en = 1'b1;
        end else if (state_reg == ST_SHIFT) begin
            wr_en = 1'b1;
            wr_addr = slot_of(op_prog_reg, sh_idx_reg);
            wr_data = op_ins_reg ? step_mem[slot_of(op_prog_reg, sh_idx_reg - 7'h1)]
                : step_mem[slot_of(op_prog_reg, sh_idx_reg + 7'h1)];
        end else if (state_reg == ST_PLACE && op_ins_reg) begin
            wr_en = 1'b1;
            wr_addr = slot_of(op_prog_reg, op_step_reg);
            wr_data = {op_mem_reg, IVAL_INSERT};
        end
    end

    // step store has no reset; counts keep unread slots out of reach
    always_ff @(posedge i_mclk) begin
        if (wr_en) begin
            step_mem[wr_addr] <= wr_data;
        end
        if (do_op && i_cmd_op == OP_SAVE_COND) begin
            cond_mem[prog_ix] <= i_present_cond;
        end
    end

    // per-program counts, names and repeat bits, plus the shared pool usage
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int k = 0; k < NUM_ENTRIES; k++) begin
                cnt_arr[k] <= STEP_RESET;
                name_arr[k] <= NAME_RESET;
            end
            rep_reg <= '0;
            pool_reg <= POOL_RESET;
        end else if (state_reg == ST_PLACE) begin
            cnt_arr[op_prog_reg] <= op_ins_reg ? cnt_arr[op_prog_reg] + 7'h1 : cnt_arr[op_prog_reg] - 7'h1;
            pool_reg <= op_ins_reg ? pool_reg + 9'h1 : pool_reg - 9'h1;
        end else if (do_op) begin
            if (i_cmd_op == OP_WRITE && append) begin
                cnt_arr[prog_ix] <= cur_cnt + 7'h1;
                pool_reg <= pool_reg + 9'h1;
            end
            if (i_cmd_op == OP_CLEAR) begin
                cnt_arr[prog_ix] <= STEP_RESET;
                pool_reg <= pool_reg - 9'(cur_cnt);
            end
            if (i_cmd_op == OP_NAME) begin
                name_arr[prog_ix] <= i_cmd_name;
            end
            if (i_cmd_op == OP_REPEAT) begin
                rep_reg[prog_ix] <= i_cmd_flag;
            end
        end
    end

    // operand capture for the multi-cycle insert and remove
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            sh_idx_reg <= STEP_RESET;
            op_prog_reg <= STEP_RESET;
            op_step_reg <= STEP_RESET;
            op_mem_reg <= STEP_RESET;
            op_ins_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sh_idx_reg <= sh_idx_next;
            if (cmd_go) begin
                op_prog_reg <= prog_ix;
                op_step_reg <= i_cmd_step;
                op_mem_reg <= i_cmd_mem;
                op_ins_reg <= i_cmd_op == OP_INSERT;
            end
        end
    end

    // answers, condition load, error flags and screen request; strobes and flags are one-cycle pulses, answer and condition data held
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rsp_valid_reg <= 1'b0;
            cond_load_reg <= 1'b0;
            edit_reg <= 1'b0;
            run_loaded_reg <= 1'b0;
            esr_reg <= 8'h00;
            rsp_mem_reg <= STEP_RESET;
            rsp_ival_reg <= STEP_RESET;
            rsp_count_reg <= STEP_RESET;
            rsp_name_reg <= NAME_RESET;
            rsp_rep_reg <= 1'b0;
            cond_out_reg <= '0;
            run_prog_reg <= STEP_RESET;
        end else begin
            rsp_valid_reg <= do_op && is_query;
            cond_load_reg <= do_op && i_cmd_op == OP_LOAD_COND;
            edit_reg <= do_op && i_cmd_op == OP_WRITE && i_auto_test_screen;
            run_loaded_reg <= do_op && i_cmd_op == OP_RUN_SEL;
            esr_reg <= 8'h00;
            esr_reg[ESR_SYNTAX_BIT] <= cmd_go && syn_err;
            esr_reg[ESR_EXEC_BIT] <= cmd_go && !syn_err && exe_err;
            if (do_op) begin
                rsp_mem_reg <= q_entry[13:7];
                rsp_ival_reg <= q_entry[6:0];
                rsp_count_reg <= cur_cnt;
                rsp_name_reg <= name_arr[prog_ix];
                rsp_rep_reg <= rep_reg[prog_ix];
            end
            if (do_op && i_cmd_op == OP_LOAD_COND) begin
                cond_out_reg <= cond_mem[prog_ix];
            end
            if (do_op && i_cmd_op == OP_RUN_SEL) begin
                run_prog_reg <= prog_ix;
            end
        end
    end

    // operator key comes from a pin
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            go_meta_reg <= 1'b0;
            go_sync_reg <= 1'b0;
        end else begin
            go_meta_reg <= i_operator_go;
            go_sync_reg <= go_meta_reg;
        end
    end

    // a new program selection stops the sequencer in the same cycle
    tpss_seq #(
        .TENTH_CYCLES(TENTH_CYCLES)
    ) u_seq (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_start(i_run_start),
        .i_stop(i_run_stop || (do_op && i_cmd_op == OP_RUN_SEL)),
        .i_count(run_cnt),
        .i_repeat(rep_reg[run_prog_reg]),
        .i_ival(run_entry[6:0]),
        .i_operator_go(go_sync_reg),
        .o_step(run_step),
        .o_active(o_run_active),
        .o_step_pulse(o_run_step_pulse)
    );

    assign o_cmd_ready = state_reg == ST_IDLE;
    assign o_rsp_valid = rsp_valid_reg;
    assign o_rsp_mem = rsp_mem_reg;
    assign o_rsp_ival = rsp_ival_reg;
    assign o_rsp_name = rsp_name_reg;
    assign o_rsp_repeat = rsp_rep_reg;
    assign o_rsp_count = rsp_count_reg;
    assign o_cond_load = cond_load_reg;
    assign o_cond_data = cond_out_reg;
    assign o_esr_set = esr_reg;
    assign o_goto_edit_screen = edit_reg;
    assign o_run_loaded = run_loaded_reg;
    assign o_run_prog = run_prog_reg;
    assign o_run_step = run_step;
    assign o_run_mem = run_entry[13:7];
endmodule
